// [logic/imc_master.sv]
`default_nettype none
`include "imc_map.svh"
module imc_master
  import imc_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // Configuration
  input  wire logic                   controller_enable,
  input  wire logic                   input_filter_en,
  input  wire logic                   baud_tick_irq_en,
  input  wire logic                   tx_empty_irq_en,
  input  wire logic                   pin_alt_sel,
  input  wire logic [`IMC_BAUD_W-1:0] baud_reload,
  // Software requests
  input  wire logic                   start_set,
  input  wire logic                   stop_set,
  input  wire logic                   nak_set,
  input  wire logic                   flush,
  input  wire logic                   data_wr,
  input  wire logic [7:0]             data_in,
  input  wire logic                   data_rd,
  // Status and events
  output var  logic [7:0]             rx_data,
  output logic                        tx_data_empty_flag,
  output logic                        start_pending,
  output logic                        stop_pending,
  output logic                        nak_pending,
  output logic                        bus_busy,
  output logic                        addr_tenbit,
  output logic                        rx_irq,
  output logic                        nak_irq,
  output logic                        tx_irq,
  output logic                        baud_irq,
  // Bus pins
  input  wire logic                   scl_in,
  output logic                        scl_out,
  output logic                        scl_oe,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe
);
  imc_in_if lines ();

  assign lines.raw[`IMC_LINE_SCL] = scl_in;
  assign lines.raw[`IMC_LINE_SDA] = sda_in;
  assign lines.en                 = input_filter_en;

  imc_filter u_filter (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .lines   (lines)
  );

  logic scl_f;
  logic sda_f;
  assign scl_f = lines.clean[`IMC_LINE_SCL];
  assign sda_f = lines.clean[`IMC_LINE_SDA];

  imc_state_e             state_reg;
  imc_state_e             state_next;
  logic [`IMC_BAUD_W-1:0] cnt_reg;
  logic [`IMC_BAUD_W-1:0] cnt_next;
  logic [7:0]             shift_reg;
  logic [7:0]             shift_next;
  logic [3:0]             bit_reg;
  logic [3:0]             bit_next;
  logic [7:0]             tx_data_reg;
  logic [7:0]             tx_data_next;
  logic                   tx_full_reg;
  logic                   tx_full_next;
  logic [7:0]             rx_data_next;
  logic                   rx_full_reg;
  logic                   rx_full_next;
  logic                   rd_mode_reg;
  logic                   rd_mode_next;
  logic                   first_reg;
  logic                   first_next;
  logic                   tenbit_reg;
  logic                   tenbit_next;
  logic                   start_reg;
  logic                   start_next;
  logic                   stop_reg;
  logic                   stop_next;
  logic                   nak_reg;
  logic                   nak_next;
  logic                   nak_flag_reg;
  logic                   nak_flag_next;
  logic                   scl_pull_reg;
  logic                   scl_pull_next;
  logic                   sda_pull_reg;
  logic                   sda_pull_next;
  logic                   baud_irq_reg;
  logic                   baud_irq_next;

  logic [`IMC_BAUD_W-1:0] half_cyc;
  logic                   cnt_run;
  logic                   stretch;
  logic                   tick;
  logic                   sending;
  logic                   load;

  assign half_cyc = (baud_reload < `IMC_BAUD_W'(`IMC_MIN_HALF_CYC)) ?
                    `IMC_BAUD_W'(`IMC_MIN_HALF_CYC) : baud_reload;
  assign stretch  = !scl_pull_reg && !scl_f &&
                    (state_reg == ST_HI || state_reg == ST_STA_A ||
                     state_reg == ST_STP_B || state_reg == ST_STA_B);
  assign cnt_run  = (controller_enable || baud_tick_irq_en) && !stretch;
  assign tick     = cnt_run && (cnt_reg == '0);
  assign sending  = first_reg || !rd_mode_reg;

  always_comb begin
    cnt_next      = cnt_reg;
    baud_irq_next = 1'b0;
    if (!cnt_run) begin
      cnt_next = half_cyc - `IMC_BAUD_W'(1);
    end else if (tick) begin
      cnt_next      = half_cyc - `IMC_BAUD_W'(1);
      baud_irq_next = baud_tick_irq_en;
    end else begin
      cnt_next = cnt_reg - `IMC_BAUD_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg      <= '0;
      baud_irq_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      baud_irq_reg <= baud_irq_next;
    end
  end

  always_comb begin
    state_next    = state_reg;
    shift_next    = shift_reg;
    bit_next      = bit_reg;
    tx_data_next  = tx_data_reg;
    tx_full_next  = tx_full_reg;
    rx_data_next  = rx_data;
    rx_full_next  = rx_full_reg;
    rd_mode_next  = rd_mode_reg;
    first_next    = first_reg;
    tenbit_next   = tenbit_reg;
    start_next    = start_reg;
    stop_next     = stop_reg;
    nak_next      = nak_reg;
    nak_flag_next = nak_flag_reg;
    scl_pull_next = scl_pull_reg;
    sda_pull_next = sda_pull_reg;
    load          = 1'b0;
    if (data_rd) begin
      rx_full_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        scl_pull_next = 1'b0;
        sda_pull_next = 1'b0;
        if (tick && stop_reg) begin
          stop_next = 1'b0;
        end else if (tick && start_reg && tx_full_reg) begin
          state_next = ST_STA_A;
        end
      end
      ST_STA_A: begin
        // Release data before clock so a repeated start is not seen as a stop
        scl_pull_next = scl_pull_reg && sda_pull_reg;
        sda_pull_next = 1'b0;
        if (tick) begin
          state_next = ST_STA_B;
        end
      end
      ST_STA_B: begin
        sda_pull_next = 1'b1;
        if (tick) begin
          state_next = ST_STA_C;
          start_next = 1'b0;
        end
      end
      ST_STA_C: begin
        scl_pull_next = 1'b1;
        if (tick) begin
          load          = 1'b1;
          first_next    = 1'b1;
          nak_flag_next = 1'b0;
          rd_mode_next  = tx_data_reg[0];
          tenbit_next   = (tx_data_reg[7:3] == `IMC_TENBIT_PREFIX);
          state_next    = ST_LO;
        end
      end
      ST_LO: begin
        scl_pull_next = 1'b1;
        // MSB first drive, only once the clock is already held low
        if (scl_pull_reg && bit_reg != `IMC_ACK_BIT) begin
          sda_pull_next = sending && !shift_reg[7];
        end else if (scl_pull_reg) begin
          sda_pull_next = !sending && !nak_reg;
        end
        if (tick) begin
          state_next = ST_HI;
        end
      end
      ST_HI: begin
        scl_pull_next = 1'b0;
        if (tick) begin
          if (bit_reg != `IMC_ACK_BIT) begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_next   = bit_reg + 4'h1;
            state_next = ST_LO;
          end else begin
            first_next = 1'b0;
            state_next = ST_HOLD;
            if (sending) begin
              if (sda_f) begin
                nak_flag_next = 1'b1;
              end
            end else begin
              rx_data_next = shift_reg;
              rx_full_next = 1'b1;
              if (nak_reg) begin
                nak_next      = 1'b0;
                nak_flag_next = 1'b1;
              end
            end
          end
        end
      end
      ST_HOLD: begin
        scl_pull_next = 1'b1;
        if (tick) begin
          if (stop_reg) begin
            state_next = ST_STP_A;
          end else if (start_reg && tx_full_reg) begin
            state_next = ST_STA_A;
          end else if (nak_flag_reg) begin
            state_next = ST_HOLD;
          end else if (rd_mode_reg && !rx_full_reg) begin
            bit_next   = 4'h0;
            state_next = ST_LO;
          end else if (!rd_mode_reg && tx_full_reg) begin
            load       = 1'b1;
            state_next = ST_LO;
          end
        end
      end
      ST_STP_A: begin
        sda_pull_next = 1'b1;
        if (tick) begin
          state_next = ST_STP_B;
        end
      end
      ST_STP_B: begin
        scl_pull_next = 1'b0;
        if (tick) begin
          state_next = ST_STP_C;
        end
      end
      ST_STP_C: begin
        sda_pull_next = 1'b0;
        if (tick) begin
          stop_next  = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (load) begin
      shift_next   = tx_data_reg;
      bit_next     = 4'h0;
      tx_full_next = 1'b0;
    end
    if (data_wr) begin
      tx_data_next = data_in;
      tx_full_next = 1'b1;
    end
    if (flush) begin
      tx_full_next = 1'b0;
    end
    if (start_set) begin
      start_next = 1'b1;
    end
    if (stop_set) begin
      stop_next = 1'b1;
    end
    if (nak_set) begin
      nak_next = 1'b1;
    end
    if (!controller_enable) begin
      state_next    = ST_IDLE;
      start_next    = 1'b0;
      stop_next     = 1'b0;
      nak_next      = 1'b0;
      nak_flag_next = 1'b0;
      scl_pull_next = 1'b0;
      sda_pull_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      shift_reg    <= 8'h00;
      bit_reg      <= 4'h0;
      tx_data_reg  <= 8'h00;
      tx_full_reg  <= 1'b0;
      rx_data      <= 8'h00;
      rx_full_reg  <= 1'b0;
      rd_mode_reg  <= 1'b0;
      first_reg    <= 1'b0;
      tenbit_reg   <= 1'b0;
      start_reg    <= 1'b0;
      stop_reg     <= 1'b0;
      nak_reg      <= 1'b0;
      nak_flag_reg <= 1'b0;
      scl_pull_reg <= 1'b0;
      sda_pull_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      bit_reg      <= bit_next;
      tx_data_reg  <= tx_data_next;
      tx_full_reg  <= tx_full_next;
      rx_data      <= rx_data_next;
      rx_full_reg  <= rx_full_next;
      rd_mode_reg  <= rd_mode_next;
      first_reg    <= first_next;
      tenbit_reg   <= tenbit_next;
      start_reg    <= start_next;
      stop_reg     <= stop_next;
      nak_reg      <= nak_next;
      nak_flag_reg <= nak_flag_next;
      scl_pull_reg <= scl_pull_next;
      sda_pull_reg <= sda_pull_next;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = pin_alt_sel && scl_pull_reg;
  assign sda_oe  = pin_alt_sel && sda_pull_reg;

  assign tx_data_empty_flag = !tx_full_reg;
  assign start_pending      = start_reg;
  assign stop_pending       = stop_reg;
  assign nak_pending        = nak_reg;
  assign bus_busy           = (state_reg != ST_IDLE);
  assign addr_tenbit        = tenbit_reg;
  assign rx_irq             = rx_full_reg;
  assign nak_irq            = nak_flag_reg;
  assign tx_irq             = tx_empty_irq_en && controller_enable && !tx_full_reg;
  assign baud_irq           = baud_irq_reg;
endmodule : imc_master
`default_nettype wire

// [logic/imc_map.svh]
// Notes on behaviour
// - Acts only as bus master; never answers as an addressed slave.
// - Single master assumed; no hardware arbitration, software resolves contention.
// - Address, data and acknowledge travel on the data line, MSB first.
// - With the alternate function selected both pins drive open-drain only.
// - The controller makes the serial clock and moves whole bytes.
// - Slave may hold clock low in high phase; resume after release.
// - Any number of data bytes per transfer until stop is requested.
// - Serial clock supports data rates up to 400 kbit/s.
// - Single-byte read: start, address, byte, NAK, receive event with NAK event, stop.
// - Ten-bit first byte is 11110, two high address bits, direction bit.
// - Ten-bit read: write prefix, second byte, repeated start, read prefix.
// - Start goes out only once a byte is loaded; otherwise it waits.
// - Start during a byte follows its acknowledge; a pending stop goes first.
// - Start request clears after start sent or when disabled, not by software.
// - Stop follows the byte being sent or the byte being received.
// - Stop request clears after stop sent, at a baud tick while idle, or when disabled, not by software.
// - Baud tick event each time the baud counter reaches zero.
// - Transmit-empty event while the data register is empty and enabled.
// - NAK request not-acknowledges the next read byte, then clears itself.
// - Flush empties the data register and sets the empty flag.
// - Filter rejects one-cycle pulses on both inputs, adds three cycles latency.
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH
`define IMC_CLK_HZ        10000000
`define IMC_MAX_BIT_HZ    400000
`define IMC_MIN_HALF_CYC  ((`IMC_CLK_HZ + 2 * `IMC_MAX_BIT_HZ - 1) / (2 * `IMC_MAX_BIT_HZ))
`define IMC_BAUD_W        16
`define IMC_ACK_BIT       4'h8
`define IMC_TENBIT_PREFIX 5'h1E
`define IMC_LINE_SCL      0
`define IMC_LINE_SDA      1
`endif

// [logic/imc_pkg.sv]
`default_nettype none
package imc_pkg;
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_STA_A = 10'h002,
    ST_STA_B = 10'h004,
    ST_STA_C = 10'h008,
    ST_LO    = 10'h010,
    ST_HI    = 10'h020,
    ST_HOLD  = 10'h040,
    ST_STP_A = 10'h080,
    ST_STP_B = 10'h100,
    ST_STP_C = 10'h200
  } imc_state_e;
endpackage : imc_pkg
`default_nettype wire

// [logic/imc_in_if.sv]
`default_nettype none
interface imc_in_if;
  logic [1:0] raw;
  logic       en;
  logic [1:0] clean;
  modport filt (input raw, input en, output clean);
  modport ctl  (output raw, output en, input clean);
endinterface : imc_in_if
`default_nettype wire

// [logic/imc_filter.sv]
`default_nettype none
module imc_filter
  import imc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus lines
  imc_in_if.filt   lines
);
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      logic s1_reg;
      logic s2_reg;
      logic h0_reg;
      logic h1_reg;
      logic f_reg;
      logic f_next;
      always_comb begin
        f_next = (h0_reg == h1_reg) ? h1_reg : f_reg;
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg <= 1'b1;
          s2_reg <= 1'b1;
          h0_reg <= 1'b1;
          h1_reg <= 1'b1;
          f_reg  <= 1'b1;
        end else begin
          s1_reg <= lines.raw[i];
          s2_reg <= s1_reg;
          h0_reg <= s2_reg;
          h1_reg <= h0_reg;
          f_reg  <= f_next;
        end
      end
      assign lines.clean[i] = lines.en ? f_reg : s2_reg;
    end
  endgenerate
endmodule : imc_filter
`default_nettype wire

// [verif/imc_master_checker.sv]
`default_nettype none
module imc_master_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Controls
  input wire logic controller_enable,
  input wire logic tx_empty_irq_en,
  input wire logic pin_alt_sel,
  input wire logic flush,
  input wire logic data_wr,
  // Status
  input wire logic tx_data_empty_flag,
  input wire logic start_pending,
  input wire logic stop_pending,
  input wire logic nak_pending,
  input wire logic bus_busy,
  input wire logic nak_irq,
  input wire logic tx_irq,
  input wire logic baud_irq,
  // Pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin output not low");
  a_alt_off_release: assert property (!pin_alt_sel [*2] |-> !scl_oe && !sda_oe)
    else $error("pin pulled with alternate function off");
  a_tx_irq_level: assert property (
    tx_irq == (tx_empty_irq_en && controller_enable && tx_data_empty_flag))
    else $error("tx_irq wrong");
  a_flush_empties: assert property (flush |=> tx_data_empty_flag)
    else $error("flush left data");
  a_start_needs_data: assert property (
    !bus_busy && tx_data_empty_flag && !data_wr |=> !bus_busy)
    else $error("engine left idle without data");
  a_stop_before_start: assert property (
    start_pending && stop_pending && scl_oe && controller_enable |=> start_pending)
    else $error("start sent ahead of pending stop");
  a_start_cleared: assert property (
    $fell(start_pending) && $past(controller_enable) && pin_alt_sel
    |-> ##[0:1] sda_oe && !scl_oe)
    else $error("start request cleared without start");
  a_stop_cleared: assert property (
    $fell(stop_pending) && $past(controller_enable) && pin_alt_sel
    |-> ##[0:1] !sda_oe && !scl_oe)
    else $error("stop request cleared without stop");
  a_nak_event_set: assert property (
    $fell(nak_pending) && $past(controller_enable) |-> ##[0:1] nak_irq)
    else $error("nak request cleared without nak event");
  a_baud_spacing: assert property (baud_irq |=> !baud_irq [*8])
    else $error("baud events too close");
  a_stretch_hold: assert property (bus_busy && !scl_oe && !scl_in |=> !scl_oe)
    else $error("clock pulled during stretch");
  a_low_phase_min: assert property (
    $rose(scl_oe) |-> (scl_oe || !controller_enable || !pin_alt_sel) [*8])
    else $error("clock low phase too short");
endmodule : imc_master_checker

bind imc_master imc_master_checker i_imc_master_checker (
  .ref_clk, .rstn, .controller_enable, .tx_empty_irq_en, .pin_alt_sel, .flush,
  .data_wr, .tx_data_empty_flag, .start_pending, .stop_pending, .nak_pending,
  .bus_busy, .nak_irq, .tx_irq, .baud_irq, .scl_in, .scl_out, .scl_oe, .sda_out,
  .sda_oe
);
`default_nettype wire

// [verif/imc_slave.sv]
`default_nettype none
module imc_slave (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour
  input  wire logic       stretch,
  input  wire logic [7:0] rd_byte,
  // Pulls and observations
  output var  logic       scl_low,
  output var  logic       sda_low,
  output var  logic [7:0] addr,
  output var  logic [7:0] last,
  output var  logic       mack,
  output var  logic       stopped,
  output var  int         nbytes
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bitc;
  logic       first;
  logic       rd;
  logic [7:0] sh;
  initial begin
    {scl_low, sda_low, mack, stopped, first, rd} = 6'h00;
    {addr, last, sh} = 24'h000000;
    bitc = 0;
    nbytes = 0;
  end
  // Start: the master's next clock fall opens bit count zero
  always @(negedge sda) if (scl) begin
    bitc = -1;
    first = 1'b1;
    stopped = 1'b0;
  end
  always @(posedge sda) if (scl) stopped = 1'b1;
  always @(posedge scl) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else mack = sda;
  end
  always @(negedge scl) begin
    bitc = bitc + 1;
    sda_low = 1'b0;
    if (bitc == 8) begin
      if (first) begin
        rd = sh[0];
        addr = sh;
      end
      if (first || !rd) begin
        last = sh;
        nbytes = nbytes + 1;
        sda_low = 1'b1;
      end
      if (stretch) begin
        scl_low = 1'b1;
        scl_low <= #5000 1'b0;
      end
    end else if (bitc == 9) begin
      bitc = 0;
      first = 1'b0;
      if (rd && mack) rd = 1'b0;
    end
    if (rd && !first && bitc < 8) sda_low = ~rd_byte[7 - bitc];
  end
endmodule : imc_slave
`default_nettype wire

// [verif/imc_master_tb.sv]
`default_nettype none
module imc_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Design inputs
  logic ref_clk = 1'b0, rstn = 1'b0, controller_enable = 1'b0;
  logic input_filter_en = 1'b0, baud_tick_irq_en = 1'b0, tx_empty_irq_en = 1'b0;
  logic pin_alt_sel = 1'b0, start_set = 1'b0, stop_set = 1'b0, nak_set = 1'b0;
  logic flush = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
  logic [15:0] baud_reload = 16'h000D;
  logic [7:0]  data_in = 8'h00;
  // Design outputs and bus input wires
  logic [7:0]  rx_data;
  logic tx_data_empty_flag, start_pending, stop_pending, nak_pending, bus_busy;
  logic addr_tenbit, rx_irq, nak_irq, tx_irq, baud_irq;
  logic scl_out, scl_oe, sda_out, sda_oe;
  wire logic   scl_in;
  wire logic   sda_in;
  // Partner side
  logic        stretch = 1'b0;
  logic [7:0]  rd_byte = 8'h00;
  logic [7:0]  s_addr, s_last;
  logic        s_scl_low, s_sda_low, s_mack, s_stopped;
  int          s_nbytes;
  int          err_total = 0;
  int          samples_checked = 0;

  // Pulled-up open-drain wires
  assign scl_in = (scl_oe ? scl_out : 1'b1) & ~s_scl_low;
  assign sda_in = (sda_oe ? sda_out : 1'b1) & ~s_sda_low;

  imc_master i_imc_master (.*);
  imc_slave i_imc_slave (.scl(scl_in), .sda(sda_in), .stretch, .rd_byte,
    .scl_low(s_scl_low), .sda_low(s_sda_low), .addr(s_addr), .last(s_last),
    .mack(s_mack), .stopped(s_stopped), .nbytes(s_nbytes));

  always #50 ref_clk = ~ref_clk;

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Request pulse order: start, stop, nak, flush
  task automatic req(input logic [3:0] m);
    @(posedge ref_clk);
    {start_set, stop_set, nak_set, flush} <= m;
    @(posedge ref_clk);
    {start_set, stop_set, nak_set, flush} <= 4'h0;
  endtask : req

  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    data_in <= d;
    data_wr <= 1'b1;
    @(posedge ref_clk);
    data_wr <= 1'b0;
  endtask : wr

  function automatic logic pick(input int s);
    case (s)
      0: pick = bus_busy;
      1: pick = rx_irq;
      2: pick = nak_irq;
      default: pick = tx_data_empty_flag;
    endcase
  endfunction : pick

  task automatic await(input int s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pick(s) !== v && n < 3000);
    if (n >= 3000) begin
      err_total++;
      $display("mismatch at %0t: wait timed out", $time);
      conclude();
    end
  endtask : await

  task automatic rd_tail(input logic [7:0] exp, input logic [3:0] m);
    await(1, 1'b1);
    chk8(rx_data, exp);
    await(2, 1'b1);
    chk1(nak_pending, 1'b0);
    chk1(s_mack, 1'b1);
    @(posedge ref_clk);
    data_rd <= 1'b1;
    @(posedge ref_clk);
    data_rd <= 1'b0;
    req(m);
    await(0, 1'b0);
    chk1(stop_pending, 1'b0);
    chk1(rx_irq, 1'b0);
    chk1(s_stopped, 1'b1);
  endtask : rd_tail

  task automatic count_baud(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (130) begin
      @(negedge ref_clk);
      if (baud_irq === 1'b1) n++;
    end
    chk8(8'(n), exp);
  endtask : count_baud

  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    controller_enable <= 1'b1;
    tx_empty_irq_en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pin_alt_sel <= 1'b1;
    @(negedge ref_clk);
    chk1(tx_irq, 1'b1);
    wr(8'hA0);
    @(negedge ref_clk);
    chk1(tx_irq, 1'b0);
    req(4'b0001);
    @(negedge ref_clk);
    chk1(tx_data_empty_flag, 1'b1);
    req(4'b1000);
    repeat (40) @(negedge ref_clk);
    chk1(bus_busy, 1'b0);
    chk1(start_pending, 1'b1);
    // Write of two data bytes with a stretching slave
    stretch = 1'b1;
    wr(8'hA0);
    await(3, 1'b1);
    chk1(start_pending, 1'b0);
    wr(8'h3C);
    await(3, 1'b1);
    wr(8'hC5);
    await(3, 1'b1);
    req(4'b0100);
    await(0, 1'b0);
    chk8(s_addr, 8'hA0);
    chk8(s_last, 8'hC5);
    chk8(8'(s_nbytes), 8'h03);
    chk1(s_stopped, 1'b1);
    // Ten-bit read through the input filter
    stretch = 1'b0;
    rd_byte = 8'h96;
    @(posedge ref_clk);
    input_filter_en <= 1'b1;
    wr(8'hF6);
    req(4'b1000);
    await(3, 1'b1);
    wr(8'h5A);
    await(3, 1'b1);
    chk1(addr_tenbit, 1'b1);
    wr(8'hF7);
    req(4'b1010);
    await(3, 1'b1);
    wr(8'hA1);
    rd_tail(8'h96, 4'b1110);
    chk1(start_pending, 1'b1);
    chk8(s_addr, 8'hF7);
    // Seven-bit single-byte read behind the stop-then-start request
    @(posedge ref_clk);
    input_filter_en <= 1'b0;
    rd_byte = 8'h69;
    rd_tail(8'h69, 4'b0100);
    chk1(addr_tenbit, 1'b0);
    // Disable drops pending requests
    req(4'b1010);
    @(negedge ref_clk);
    chk1(nak_pending, 1'b1);
    @(posedge ref_clk);
    controller_enable <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk1(start_pending, 1'b0);
    chk1(nak_pending, 1'b0);
    req(4'b0100);
    @(negedge ref_clk);
    chk1(stop_pending, 1'b0);
    // Baud events while disabled, at the rate floor and at twice it
    @(posedge ref_clk);
    baud_tick_irq_en <= 1'b1;
    baud_reload <= 16'h0004;
    repeat (20) @(posedge ref_clk);
    count_baud(8'h0A);
    @(posedge ref_clk);
    baud_reload <= 16'h001A;
    repeat (30) @(posedge ref_clk);
    count_baud(8'h05);
    conclude();
  end
endmodule : imc_master_tb
`default_nettype wire
